// >>> src/elm_link_monitor_regs.sv
// management registers of the early link-loss and low-power monitor
`timescale 1ns/1ps
`default_nettype none
module elm_link_monitor_regs
  import elm_pkg::*;
#(
  parameter int ERR_WIDTH = ELM_ERR_WIDTH
)
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire elm_mgmt_req_s MGMT_REQ,
  output logic [15:0] MGMT_RDATA,
  output logic MGMT_ACK,
  input wire elm_phy_status_s PHY_STATUS,
  input wire logic [ERR_WIDTH-1:0] SIGNAL_ERR_DIM_A,
  output logic EARLY_LOSS_EVENT,
  output logic EARLY_LOSS_LATCHED,
  output logic RX_CLK_STOP_ALLOWED
);
  // ========================================================================
  // elaboration check: error value must fit the low byte
  if (ERR_WIDTH < 1 || ERR_WIDTH > 8)
  begin : g_bad
    $error("elm_link_monitor_regs: ERR_WIDTH must be 1..8");
  end
  // ========================================================================
  // state
  logic [15:0] early_loss_enable_reg;
  logic [15:0] clk_stop_reg;
  logic resolved_low_power_capable;
  logic [ERR_WIDTH-1:0] signal_error_dim_a;
  logic [15:0] rdata;
  logic ack;
  logic [15:0] next_enable;
  logic [15:0] next_clk_stop;
  logic next_resolved;
  logic [ERR_WIDTH-1:0] next_err;
  logic [15:0] next_rdata;
  logic next_ack;
  logic early_loss_latched_flag;
  logic [3:0] src_hit;
  logic [3:0] src_en;
  // ========================================================================
  // writable registers: only mapped writable bits take the write
  always_comb
  begin
    next_enable = early_loss_enable_reg;
    next_clk_stop = clk_stop_reg;
    if (MGMT_REQ.wr && MGMT_REQ.addr == ELM_ADDR_LOSS_EN)
    begin
      next_enable = MGMT_REQ.wdata & ELM_MASK_LOSS_EN;
    end
    if (MGMT_REQ.wr && MGMT_REQ.addr == ELM_ADDR_CLK_STOP)
    begin
      next_clk_stop = MGMT_REQ.wdata & ELM_MASK_CLK_STOP;
    end
  end
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      early_loss_enable_reg <= ELM_RST_LOSS_EN;
      clk_stop_reg <= ELM_RST_CLK_STOP;
    end
    else
    begin
      early_loss_enable_reg <= next_enable;
      clk_stop_reg <= next_clk_stop;
    end
  end
  // ========================================================================
  // status captures: values only valid once the link is up
  always_comb
  begin
    next_resolved = PHY_STATUS.link_up & PHY_STATUS.resolved_capable;
    next_err = signal_error_dim_a;
    if (PHY_STATUS.link_up && PHY_STATUS.tx100_mode)
    begin
      next_err = SIGNAL_ERR_DIM_A;
    end
  end
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      resolved_low_power_capable <= 1'b0;
      signal_error_dim_a <= '0;
    end
    else
    begin
      resolved_low_power_capable <= next_resolved;
      signal_error_dim_a <= next_err;
    end
  end
  // ========================================================================
  // early loss sources, order: pcs, stuck, zero, invalid
  assign src_hit = {PHY_STATUS.pcs_rx_error, PHY_STATUS.slicer_stuck,
                    PHY_STATUS.slicer_zero, PHY_STATUS.slicer_invalid};
  assign src_en = {early_loss_enable_reg[ELM_BIT_PCS_ERR],
                   early_loss_enable_reg[ELM_BIT_SLICER_STUCK],
                   early_loss_enable_reg[ELM_BIT_SLICER_ZERO],
                   early_loss_enable_reg[ELM_BIT_SLICER_INVALID]};
  elm_loss_detect #(
    .NUM_SRC(4)
  ) u_detect (
    .sys_clk(SYS_CLK),
    .rst_n(RST_N),
    .src_hit(src_hit),
    .src_en(src_en),
    .tx100_mode(PHY_STATUS.tx100_mode),
    .link_up_start(PHY_STATUS.link_up_start),
    .loss_pulse(EARLY_LOSS_EVENT),
    .loss_latched(early_loss_latched_flag)
  );
  // ========================================================================
  // read mux: reserved bits and unmapped addresses read as zero
  always_comb
  begin
    next_rdata = ELM_RST_ZERO;
    next_ack = MGMT_REQ.rd | MGMT_REQ.wr;
    if (MGMT_REQ.rd)
    begin
      case (MGMT_REQ.addr)
        ELM_ADDR_RESOLVED:
        begin
          next_rdata[ELM_BIT_RESOLVED] = resolved_low_power_capable;
        end
        ELM_ADDR_ERR_DIM_A:
        begin
          next_rdata[ERR_WIDTH-1:0] = signal_error_dim_a;
        end
        ELM_ADDR_LOSS_EN:
        begin
          next_rdata = early_loss_enable_reg;
        end
        ELM_ADDR_LOSS_LAT:
        begin
          next_rdata[ELM_BIT_LOSS_LATCHED] = early_loss_latched_flag;
        end
        ELM_ADDR_CLK_STOP:
        begin
          next_rdata = clk_stop_reg;
        end
        default:
        begin
          next_rdata = ELM_RST_ZERO;
        end
      endcase
    end
  end
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      rdata <= ELM_RST_ZERO;
      ack <= 1'b0;
    end
    else
    begin
      rdata <= next_rdata;
      ack <= next_ack;
    end
  end
  // ========================================================================
  // outputs
  assign MGMT_RDATA = rdata;
  assign MGMT_ACK = ack;
  assign EARLY_LOSS_LATCHED = early_loss_latched_flag;
  assign RX_CLK_STOP_ALLOWED = clk_stop_reg[ELM_BIT_CLK_STOP];
endmodule : elm_link_monitor_regs
`default_nettype wire

// >>> pkg/elm_pkg.sv
// constants, register map and carrier types of the early link-loss monitor
// ==========================================================================
package elm_pkg;
  // ========================================================================
  // register offsets
  localparam logic [15:0] ELM_ADDR_RESOLVED = 16'h8008;
  localparam logic [15:0] ELM_ADDR_ERR_DIM_A = 16'h8402;
  localparam logic [15:0] ELM_ADDR_LOSS_EN = 16'h8e27;
  localparam logic [15:0] ELM_ADDR_LOSS_LAT = 16'h8e38;
  localparam logic [15:0] ELM_ADDR_CLK_STOP = 16'h9400;
  // ========================================================================
  // field positions
  localparam int ELM_BIT_RESOLVED = 0;
  localparam int ELM_BIT_PCS_ERR = 7;
  localparam int ELM_BIT_SLICER_STUCK = 5;
  localparam int ELM_BIT_SLICER_ZERO = 3;
  localparam int ELM_BIT_SLICER_INVALID = 1;
  localparam int ELM_BIT_LOSS_LATCHED = 13;
  localparam int ELM_BIT_CLK_STOP = 10;
  localparam int ELM_ERR_WIDTH = 8;
  // ========================================================================
  // reset values and writable masks
  localparam logic [15:0] ELM_RST_LOSS_EN = 16'h003d;
  localparam logic [15:0] ELM_MASK_LOSS_EN = 16'h00ff;
  localparam logic [15:0] ELM_RST_CLK_STOP = 16'h0400;
  localparam logic [15:0] ELM_MASK_CLK_STOP = 16'h0400;
  localparam logic [15:0] ELM_RST_ZERO = 16'h0000;
  // ========================================================================
  // status inputs coming from the 100BASE-TX receive path
  typedef struct packed {
    logic link_up;
    logic link_up_start;
    logic tx100_mode;
    logic resolved_capable;
    logic pcs_rx_error;
    logic slicer_stuck;
    logic slicer_zero;
    logic slicer_invalid;
  } elm_phy_status_s;
  // management access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } elm_mgmt_req_s;
endpackage : elm_pkg

// >>> src/elm_loss_detect.sv
// early link-loss source gating and latched indication
`timescale 1ns/1ps
`default_nettype none
module elm_loss_detect
  import elm_pkg::*;
#(
  parameter int NUM_SRC = 4
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [NUM_SRC-1:0] src_hit,
  input wire logic [NUM_SRC-1:0] src_en,
  input wire logic tx100_mode,
  input wire logic link_up_start,
  output logic loss_pulse,
  output logic loss_latched
);
  // ========================================================================
  // elaboration check
  if (NUM_SRC < 1)
  begin : g_bad
    $error("elm_loss_detect: NUM_SRC must be at least one");
  end
  // ========================================================================
  // per-source gating
  logic [NUM_SRC-1:0] gated;
  logic next_latched;
  genvar i;
  for (i = 0; i < NUM_SRC; i++)
  begin : g_src
    assign gated[i] = src_hit[i] & src_en[i] & tx100_mode;
  end
  assign loss_pulse = |gated;
  // set wins over the link-up clear so a loss in that cycle is kept
  always_comb
  begin
    next_latched = loss_latched;
    if (link_up_start)
    begin
      next_latched = 1'b0;
    end
    if (loss_pulse)
    begin
      next_latched = 1'b1;
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      loss_latched <= 1'b0;
    end
    else
    begin
      loss_latched <= next_latched;
    end
  end
endmodule : elm_loss_detect
`default_nettype wire

// >>> testbench/elm_link_monitor_regs_properties.sv
// port assertions for the link monitor registers
`timescale 1ns/1ps
`default_nettype none
module elm_link_monitor_regs_properties
  import elm_pkg::*;
#(
  parameter int ERR_WIDTH = ELM_ERR_WIDTH
)
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire elm_mgmt_req_s MGMT_REQ,
  input wire logic [15:0] MGMT_RDATA,
  input wire logic MGMT_ACK,
  input wire elm_phy_status_s PHY_STATUS,
  input wire logic [ERR_WIDTH-1:0] SIGNAL_ERR_DIM_A,
  input wire logic EARLY_LOSS_EVENT,
  input wire logic EARLY_LOSS_LATCHED,
  input wire logic RX_CLK_STOP_ALLOWED
);
  // ==========================================================================
  // decoded requests
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  wire logic rd = MGMT_REQ.rd;
  wire logic [15:0] a = MGMT_REQ.addr;
  property p_res; rd && a == ELM_ADDR_RESOLVED |=> MGMT_RDATA[15:1] == 15'h0;
  endproperty
  a_res: assert property (p_res) else $error("resolved high bits set");
  property p_err; rd && a == ELM_ADDR_ERR_DIM_A |=> MGMT_RDATA[15:8] == 8'h0;
  endproperty
  a_err: assert property (p_err) else $error("error high byte set");
  property p_evt; !PHY_STATUS.tx100_mode |-> !EARLY_LOSS_EVENT; endproperty
  a_evt: assert property (p_evt) else $error("event outside 100 mode");
  property p_en; rd && a == ELM_ADDR_LOSS_EN |=> MGMT_RDATA[15:8] == 8'h0;
  endproperty
  a_en: assert property (p_en) else $error("enable high byte set");
  property p_set; EARLY_LOSS_EVENT |=> EARLY_LOSS_LATCHED; endproperty
  a_set: assert property (p_set) else $error("loss not latched");
  property p_hold; EARLY_LOSS_LATCHED && !PHY_STATUS.link_up_start
    |=> EARLY_LOSS_LATCHED; endproperty
  a_hold: assert property (p_hold) else $error("latch dropped");
  property p_clr; PHY_STATUS.link_up_start && !EARLY_LOSS_EVENT
    |=> !EARLY_LOSS_LATCHED; endproperty
  a_clr: assert property (p_clr) else $error("latch not cleared");
  property p_lat; rd && a == ELM_ADDR_LOSS_LAT
    |=> MGMT_RDATA == {2'b00, $past(EARLY_LOSS_LATCHED), 13'h0}; endproperty
  a_lat: assert property (p_lat) else $error("latched read wrong");
  property p_stop; MGMT_REQ.wr && a == ELM_ADDR_CLK_STOP
    |=> RX_CLK_STOP_ALLOWED == $past(MGMT_REQ.wdata[10]); endproperty
  a_stop: assert property (p_stop) else $error("clock stop wrong");
  property p_ack; rd || MGMT_REQ.wr |=> MGMT_ACK; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_quiet; !rd && !MGMT_REQ.wr
    |=> !MGMT_ACK && MGMT_RDATA == 16'h0; endproperty
  a_quiet: assert property (p_quiet) else $error("idle answer");
endmodule : elm_link_monitor_regs_properties
bind elm_link_monitor_regs elm_link_monitor_regs_properties
  #(.ERR_WIDTH(ERR_WIDTH)) i_props (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .MGMT_REQ(MGMT_REQ), .MGMT_RDATA(MGMT_RDATA), .MGMT_ACK(MGMT_ACK),
  .PHY_STATUS(PHY_STATUS), .SIGNAL_ERR_DIM_A(SIGNAL_ERR_DIM_A),
  .EARLY_LOSS_EVENT(EARLY_LOSS_EVENT), .EARLY_LOSS_LATCHED(EARLY_LOSS_LATCHED),
  .RX_CLK_STOP_ALLOWED(RX_CLK_STOP_ALLOWED));
`default_nettype wire

// >>> testbench/elm_host_model.sv
// host side model issuing single management transfers
`timescale 1ns/1ps
`default_nettype none
module elm_host_model
  import elm_pkg::*;
(
  input wire logic sys_clk,
  output var elm_mgmt_req_s req,
  input wire logic [15:0] rdata_in,
  input wire logic ack_in
);
  initial req = '0;
  // one-cycle pulse off the falling edge; the registered answer stands
  // in the next cycle, so it is taken at the following falling edge
  task automatic xfer(input logic wr, input logic [15:0] a,
    input logic [15:0] d, output logic [15:0] q, output logic k);
    @(negedge sys_clk);
    req = '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(negedge sys_clk);
    q = rdata_in;
    k = ack_in;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : xfer
endmodule : elm_host_model
`default_nettype wire

// >>> testbench/elm_link_monitor_regs_test.sv
// self-checking bench of the link monitor registers
`timescale 1ns/1ps
`default_nettype none
module elm_link_monitor_regs_test
  import elm_pkg::*;
;
  typedef struct packed {logic wr; logic [15:0] a, d, x;} elm_row_s;
  // ==========================================================================
  // register table: optional write, then read and expected value
  localparam elm_row_s ROWS [9] = '{'{1'b0, 16'h8e27, 16'h0, 16'h003d},
    '{1'b0, 16'h9400, 16'h0, 16'h0400}, '{1'b0, 16'h8008, 16'h0, 16'h0},
    '{1'b0, 16'h8e38, 16'h0, 16'h0}, '{1'b0, 16'h8402, 16'h0, 16'h0},
    '{1'b1, 16'h8e27, 16'hffff, 16'h00ff}, '{1'b1, 16'h8008, 16'hffff, 16'h0},
    '{1'b1, 16'h1234, 16'hffff, 16'h0}, '{1'b1, 16'h9400, 16'hfbff, 16'h0}};
  logic sys_clk, rst_n, ack, ev, lat, stop;
  elm_mgmt_req_s req;
  elm_phy_status_s st;
  logic [15:0] rdata, q;
  logic [7:0] err;
  int error_cnt = 0;
  int compares = 0;
  elm_link_monitor_regs i_dut (.SYS_CLK(sys_clk), .RST_N(rst_n),
    .MGMT_REQ(req), .MGMT_RDATA(rdata), .MGMT_ACK(ack), .PHY_STATUS(st),
    .SIGNAL_ERR_DIM_A(err), .EARLY_LOSS_EVENT(ev),
    .EARLY_LOSS_LATCHED(lat), .RX_CLK_STOP_ALLOWED(stop));
  elm_host_model i_host (.sys_clk(sys_clk), .req(req), .rdata_in(rdata),
    .ack_in(ack));
  task automatic check(input logic [15:0] s, input logic [15:0] x);
    compares++;
    if (s !== x)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, s, x);
    end
  endtask : check
  task automatic rw(input logic w, input logic [15:0] a, input logic [15:0] d);
    logic k;
    i_host.xfer(w, a, d, q, k);
    check({15'h0, k}, 16'h1);
  endtask : rw
  task automatic summarize();
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  // clock and a watchdog well beyond the roughly seventy cycles needed
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    #20000;
    error_cnt++;
    summarize();
  end
  // sources are walked one at a time so a crossed enable bit shows
  initial
  begin
    rst_n = 1'b0;
    st = '0;
    err = 8'h00;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    foreach (ROWS[i])
    begin
      if (ROWS[i].wr) rw(1'b1, ROWS[i].a, ROWS[i].d);
      rw(1'b0, ROWS[i].a, 16'h0);
      check(q, ROWS[i].x);
    end
    check({15'h0, stop}, 16'h0);
    st = 8'hb0;
    err = 8'ha5;
    rw(1'b0, 16'h8402, 16'h0);
    check(q, 16'h00a5);
    rw(1'b0, 16'h8008, 16'h0);
    check(q, 16'h0001);
    for (int i = 0; i < 4; i++)
    begin
      rw(1'b1, 16'h8e27, 16'h0002 << (2 * i));
      st = 8'hb0 | (8'h0f & ~(8'h01 << i));
      #1 check({15'h0, ev}, 16'h0);
      @(negedge sys_clk);
      check({15'h0, lat}, 16'h0);
      st = 8'hb0 | (8'h01 << i);
      #1 check({15'h0, ev}, 16'h1);
      @(negedge sys_clk);
      st = 8'hf0;
      check({15'h0, lat}, 16'h1);
      @(negedge sys_clk);
      st = 8'h88;
      check({15'h0, lat}, 16'h0);
      #1 check({15'h0, ev}, 16'h0);
    end
    // a loss in the link-up start cycle must win over the clear
    st = 8'hf8;
    @(negedge sys_clk);
    st = 8'hb0;
    check({15'h0, lat}, 16'h1);
    rw(1'b1, 16'h8e38, 16'h0);
    rw(1'b0, 16'h8e38, 16'h0);
    check(q, 16'h2000);
    st = 8'hf0;
    @(negedge sys_clk);
    st = 8'h88;
    check({15'h0, lat}, 16'h0);
    // outside 100 mode the error value holds; with the capability input low the resolved bit reads zero
    err = 8'h3c;
    rw(1'b0, 16'h8402, 16'h0);
    check(q, 16'h00a5);
    rw(1'b0, 16'h8008, 16'h0);
    check(q, 16'h0000);
    // latch a loss so the mid-run reset has something to clear
    st = 8'hb8;
    @(negedge sys_clk);
    st = 8'h88;
    check({15'h0, lat}, 16'h1);
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    rw(1'b0, 16'h8e27, 16'h0);
    check(q, 16'h003d);
    check({15'h0, stop}, 16'h1);
    check({15'h0, lat}, 16'h0);
    summarize();
  end
endmodule : elm_link_monitor_regs_test
`default_nettype wire
